// ===== src/fdss_sequencer.sv
// Purpose: Computes ramp breakpoints and brings up the servo drive at motion start.
// Assumes: Inputs are synchronous to sys_clk; start is taken only when idle.
// Notes:   One start runs eleven cycles; profile ticks are refused meanwhile.
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// R1: Flag word bit 1 selects manual mode.
// R2: Computer mode first breakpoint is seven percent.
// R3: Manual first breakpoint at least sixty counts.
// R4: Direction picks subtract or add for breakpoint one.
// R5: Start copies position, clears screw and filter.
// R6: Second breakpoint ninety percent via divide-by-hundred.
// R7: Manual second breakpoint stays 65 below error.
// R8: Breakpoint two uses same direction rule.
// R9: Measured velocity cleared at brake command.
// R10: Keep only upper four command port bits.
// R11: Initial drive four counts, negated when down.
// R12: Merge 12-bit drive, write port, load DAC.
// R13: Servo enable written only after DAC load.
// R14: Ramp pace counter starts at thirty.
// R15: Profile region index starts at zero.
// R16: Regions encode as 0, 2, 4, 6.
// R17: Profile timer started with control value e001.
// R18: Backup tick counter loaded with 25 last.
// R19: Sixteen-bit arithmetic; sequence atomic before ticks.
module fdss_sequencer
    import fdss_pkg::*;
(
    // Clock and reset.
    input  wire logic           sys_clk,
    input  wire logic           rst,
    // Motion command.
    input  wire logic           start,
    input  wire logic [15:0]    position_error,
    input  wire logic [15:0]    present_position,
    input  wire logic           drive_down_flag,
    input  wire logic [15:0]    system_flags,
    // Port readback and profile tick.
    input  wire logic [15:0]    port_in,
    input  wire logic           profile_tick,
    // Sequencer status.
    output logic                busy,
    output logic                done,
    output logic                tick_accept,
    // Tracking state.
    output logic [15:0]         ramp_breakpoint_one,
    output logic [15:0]         ramp_breakpoint_two,
    output logic [15:0]         previous_position,
    output logic [15:0]         screw_sensor_last,
    output logic [15:0]         screw_transition_count,
    output logic                filter_overflow,
    output logic [15:0]         filter_accum,
    output logic [15:0]         measured_velocity,
    output logic [7:0]          ramp_pace_counter,
    output logic [2:0]          profile_region_index,
    output logic [7:0]          backup_tick_counter,
    // Drive outputs.
    output logic                brake_cmd,
    output logic [15:0]         out_port,
    output logic                out_port_we,
    output logic [11:0]         dac_latch,
    output logic                dac_we,
    output logic [15:0]         timer_ctrl,
    output logic                timer_we
);

    fdss_pct_if pct ();

    fdss_pct_unit u_pct (
        .sys_clk (sys_clk),
        .rst     (rst),
        .pct     (pct)
    );

    fdss_state_t state_reg, state_next;
    logic [15:0] err_reg, err_next;
    logic [15:0] pos_reg, pos_next;
    logic        dir_reg, dir_next;
    logic        man_reg, man_next;
    logic [15:0] word_reg, word_next;
    logic [15:0] bp1_reg, bp1_next, bp2_reg, bp2_next;
    logic [15:0] prev_reg, prev_next, scrl_reg, scrl_next;
    logic [15:0] scrc_reg, scrc_next, fil_reg, fil_next, vel_reg, vel_next;
    logic        fovr_reg, fovr_next;
    logic [7:0]  pace_reg, pace_next, wdog_reg, wdog_next;
    logic [2:0]  region_reg, region_next;
    logic [15:0] port_reg, port_next, tctl_reg, tctl_next;
    logic [11:0] dac_reg, dac_next;
    logic        brake_reg, brake_next, port_we_reg, port_we_next;
    logic        dac_we_reg, dac_we_next, tim_we_reg, tim_we_next;
    logic        done_reg, done_next;
    logic [15:0] mag;
    logic [15:0] drive;

    assign pct.magnitude = err_reg;
    assign pct.percent   = (state_reg == S_BP1 || state_reg == S_BP2) ? PCT_SECOND : PCT_FIRST; // [R2] [R6]

    ////////////////////////////////////////////////////////////////////////////////////////////////
    // Next-state computation.
    always_comb begin
        state_next   = state_reg;
        err_next     = err_reg;
        pos_next     = pos_reg;
        dir_next     = dir_reg;
        man_next     = man_reg;
        word_next    = word_reg;
        bp1_next     = bp1_reg;
        bp2_next     = bp2_reg;
        prev_next    = prev_reg;
        scrl_next    = scrl_reg;
        scrc_next    = scrc_reg;
        fil_next     = fil_reg;
        fovr_next    = fovr_reg;
        vel_next     = vel_reg;
        pace_next    = pace_reg;
        wdog_next    = wdog_reg;
        region_next  = region_reg;
        port_next    = port_reg;
        tctl_next    = tctl_reg;
        dac_next     = dac_reg;
        brake_next   = 1'b0;
        port_we_next = 1'b0;
        dac_we_next  = 1'b0;
        tim_we_next  = 1'b0;
        done_next    = 1'b0;
        mag          = pct.result;
        drive        = dir_reg ? 16'(~MIN_DRIVE_STEP + 16'h0001) : MIN_DRIVE_STEP; // [R11]
        case (state_reg)
            S_IDLE: begin
                if (start) begin
                    err_next   = position_error[15] ? 16'(~position_error + 16'h0001) : position_error; // [R19]
                    pos_next   = present_position;
                    dir_next   = drive_down_flag;
                    man_next   = system_flags[MANUAL_BIT]; // [R1]
                    state_next = S_PCT1;
                end
            end
            S_PCT1: begin
                state_next = S_BP1;
            end
            S_BP1: begin
                if (man_reg && pct.result <= BP1_MANUAL_MIN) begin
                    mag = BP1_MANUAL_MIN; // [R3]
                end
                bp1_next   = dir_reg ? 16'(pos_reg + ~mag + 16'h0001) : 16'(pos_reg + mag); // [R4] [R19]
                prev_next  = pos_reg; // [R5]
                scrl_next  = pos_reg; // [R5]
                scrc_next  = 16'h0000; // [R5]
                fovr_next  = 1'b0; // [R5]
                fil_next   = 16'h0000; // [R5]
                state_next = S_BP2;
            end
            S_BP2: begin
                if (man_reg && 16'(err_reg - pct.result) < BP2_MANUAL_GAP) begin
                    mag = 16'(err_reg - BP2_MANUAL_GAP); // [R7]
                end
                bp2_next   = dir_reg ? 16'(pos_reg + ~mag + 16'h0001) : 16'(pos_reg + mag); // [R8]
                state_next = S_BRAKE;
            end
            S_BRAKE: begin
                vel_next   = 16'h0000; // [R9]
                brake_next = 1'b1;
                state_next = S_PORT_RD;
            end
            S_PORT_RD: begin
                word_next  = port_in & CMD_BITS_MASK; // [R10]
                state_next = S_PORT_WR;
            end
            S_PORT_WR: begin
                word_next    = word_reg | (drive & DAC_MASK); // [R12]
                port_next    = word_reg | (drive & DAC_MASK);
                port_we_next = 1'b1;
                state_next   = S_DAC_LD;
            end
            S_DAC_LD: begin
                dac_next    = word_reg[DAC_W-1:0]; // [R12]
                dac_we_next = 1'b1;
                state_next  = S_ENABLE;
            end
            S_ENABLE: begin
                word_next    = word_reg | SERVO_ENABLE_MASK; // [R13]
                port_next    = word_reg | SERVO_ENABLE_MASK;
                port_we_next = 1'b1;
                state_next   = S_TIMER;
            end
            S_TIMER: begin
                pace_next   = PACE_INIT; // [R14]
                region_next = REGION_ACCEL; // [R15] [R16]
                tctl_next   = TIMER_CTRL_START; // [R17]
                tim_we_next = 1'b1;
                state_next  = S_WDOG;
            end
            S_WDOG: begin
                wdog_next  = BACKUP_TICK_INIT; // [R18]
                done_next  = 1'b1;
                state_next = S_IDLE;
            end
            default: begin
                state_next = S_IDLE;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////////////////////////
    // State registers.
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            state_reg   <= S_IDLE;
            err_reg     <= 16'h0000;
            pos_reg     <= 16'h0000;
            dir_reg     <= 1'b0;
            man_reg     <= 1'b0;
            word_reg    <= 16'h0000;
            bp1_reg     <= 16'h0000;
            bp2_reg     <= 16'h0000;
            prev_reg    <= 16'h0000;
            scrl_reg    <= 16'h0000;
            scrc_reg    <= 16'h0000;
            fil_reg     <= 16'h0000;
            fovr_reg    <= 1'b0;
            vel_reg     <= 16'h0000;
            pace_reg    <= 8'h00;
            wdog_reg    <= 8'h00;
            region_reg  <= REGION_ACCEL;
            port_reg    <= 16'h0000;
            tctl_reg    <= 16'h0000;
            dac_reg     <= 12'h000;
            brake_reg   <= 1'b0;
            port_we_reg <= 1'b0;
            dac_we_reg  <= 1'b0;
            tim_we_reg  <= 1'b0;
            done_reg    <= 1'b0;
        end else begin
            state_reg   <= state_next;
            err_reg     <= err_next;
            pos_reg     <= pos_next;
            dir_reg     <= dir_next;
            man_reg     <= man_next;
            word_reg    <= word_next;
            bp1_reg     <= bp1_next;
            bp2_reg     <= bp2_next;
            prev_reg    <= prev_next;
            scrl_reg    <= scrl_next;
            scrc_reg    <= scrc_next;
            fil_reg     <= fil_next;
            fovr_reg    <= fovr_next;
            vel_reg     <= vel_next;
            pace_reg    <= pace_next;
            wdog_reg    <= wdog_next;
            region_reg  <= region_next;
            port_reg    <= port_next;
            tctl_reg    <= tctl_next;
            dac_reg     <= dac_next;
            brake_reg   <= brake_next;
            port_we_reg <= port_we_next;
            dac_we_reg  <= dac_we_next;
            tim_we_reg  <= tim_we_next;
            done_reg    <= done_next;
        end
    end

    assign busy                   = (state_reg != S_IDLE);
    assign tick_accept            = profile_tick && !busy && !done_reg; // [R19]
    assign done                   = done_reg;
    assign ramp_breakpoint_one    = bp1_reg;
    assign ramp_breakpoint_two    = bp2_reg;
    assign previous_position      = prev_reg;
    assign screw_sensor_last      = scrl_reg;
    assign screw_transition_count = scrc_reg;
    assign filter_overflow        = fovr_reg;
    assign filter_accum           = fil_reg;
    assign measured_velocity      = vel_reg;
    assign ramp_pace_counter      = pace_reg;
    assign profile_region_index   = region_reg;
    assign backup_tick_counter    = wdog_reg;
    assign brake_cmd              = brake_reg;
    assign out_port               = port_reg;
    assign out_port_we            = port_we_reg;
    assign dac_latch              = dac_reg;
    assign dac_we                 = dac_we_reg;
    assign timer_ctrl             = tctl_reg;
    assign timer_we               = tim_we_reg;

    ////////////////////////////////////////////////////////////////////////////////////////////////
    // Checks on the start sequence.
    sequence s_accept;
        start && !busy;
    endsequence

    sequence s_port_then_dac;
        out_port_we ##1 dac_we;
    endsequence

    a_seq_length: assert property (@(posedge sys_clk) disable iff (rst) s_accept |-> ##11 done) // [R19]
        else $error("Start sequence did not finish in eleven cycles.");
    a_dac_after_port: assert property (@(posedge sys_clk) disable iff (rst) dac_we |-> $past(out_port_we)) // [R12]
        else $error("DAC latch loaded without preceding port write.");
    a_enable_order: assert property (@(posedge sys_clk) disable iff (rst)
        s_port_then_dac |=> out_port_we && out_port[12] && out_port == ($past(out_port, 2) | SERVO_ENABLE_MASK)) // [R13]
        else $error("Servo enable not written right after DAC load.");
    a_dac_value: assert property (@(posedge sys_clk) disable iff (rst)
        dac_we |-> dac_latch == (dir_reg ? 12'hffc : 12'h004)) // [R11]
        else $error("Initial DAC drive value wrong.");
    a_cmd_bits_kept: assert property (@(posedge sys_clk) disable iff (rst)
        state_reg == S_PORT_RD |-> ##2 out_port[15:12] == $past(port_in[15:12], 2)) // [R10]
        else $error("Upper command bits not retained.");
    a_vel_cleared: assert property (@(posedge sys_clk) disable iff (rst) brake_cmd |-> measured_velocity == 16'h0000) // [R9]
        else $error("Velocity not cleared at brake command.");
    a_timer_start: assert property (@(posedge sys_clk) disable iff (rst)
        timer_we |-> timer_ctrl == 16'he001 && ramp_pace_counter == 8'h1e && profile_region_index == 3'h0) // [R17]
        else $error("Timer start, pace or region wrong.");
    a_wdog_last: assert property (@(posedge sys_clk) disable iff (rst) timer_we |=> done && backup_tick_counter == 8'h19) // [R18]
        else $error("Backup tick counter not loaded last.");
    a_pos_copied: assert property (@(posedge sys_clk) disable iff (rst)
        state_reg == S_BP1 |=> previous_position == pos_reg && screw_sensor_last == pos_reg && filter_accum == 16'h0000) // [R5]
        else $error("Position copy or clear missing.");
    a_mode_latched: assert property (@(posedge sys_clk) disable iff (rst) s_accept |=> man_reg == $past(system_flags[1])) // [R1]
        else $error("Manual mode bit not sampled.");
    a_no_tick_busy: assert property (@(posedge sys_clk) disable iff (rst) busy |-> !tick_accept) // [R19]
        else $error("Profile tick accepted during start sequence.");

endmodule : fdss_sequencer
`default_nettype wire

// ===== src/fdss_pkg.sv
// Purpose: Shared constants and types for the focus drive start sequencer.
// Assumes: 16-bit position words and a 12-bit DAC latch.
// Notes:   All figures used by more than one file live here.
package fdss_pkg;

    localparam int          W                 = 16;
    localparam int          MANUAL_BIT        = 1;
    localparam logic [7:0]  PCT_FIRST         = 8'h07;
    localparam logic [7:0]  PCT_SECOND        = 8'h5a;
    localparam logic [15:0] PCT_DIV           = 16'h0064;
    localparam logic [15:0] BP1_MANUAL_MIN    = 16'h003c;
    localparam logic [15:0] BP2_MANUAL_GAP    = 16'h0041;
    localparam logic [15:0] MIN_DRIVE_STEP    = 16'h0004;
    localparam logic [15:0] CMD_BITS_MASK     = 16'hf000;
    localparam logic [15:0] DAC_MASK          = 16'h0fff;
    localparam int          DAC_W             = 12;
    localparam logic [15:0] SERVO_ENABLE_MASK = 16'h1000;
    localparam logic [7:0]  PACE_INIT         = 8'h1e;
    localparam logic [2:0]  REGION_ACCEL      = 3'h0;
    localparam logic [2:0]  REGION_CRUISE     = 3'h2;
    localparam logic [2:0]  REGION_DECEL      = 3'h4;
    localparam logic [2:0]  REGION_CONVERGE   = 3'h6;
    localparam logic [15:0] TIMER_CTRL_START  = 16'he001;
    localparam logic [7:0]  BACKUP_TICK_INIT  = 8'h19;

    typedef enum logic [3:0] {
        S_IDLE, S_PCT1, S_BP1, S_BP2, S_BRAKE, S_PORT_RD,
        S_PORT_WR, S_DAC_LD, S_ENABLE, S_TIMER, S_WDOG
    } fdss_state_t;

endpackage : fdss_pkg

// ===== src/fdss_pct_if.sv
// Purpose: Carries a percentage request and its registered result.
// Assumes: One request per cycle, result one cycle later.
// Notes:   Master drives magnitude and percent.
`timescale 1ns/1ps
`default_nettype none
interface fdss_pct_if;
    logic [15:0] magnitude;
    logic [7:0]  percent;
    logic [15:0] result;
    modport master (output magnitude, output percent, input result);
    modport unit   (input magnitude, input percent, output result);
endinterface : fdss_pct_if
`default_nettype wire

// ===== src/fdss_pct_unit.sv
// Purpose: Scales a magnitude by a percentage the way the drive firmware does.
// Assumes: Magnitude is unsigned, percent at most 100.
// Notes:   Result is registered, valid the cycle after the request.
`timescale 1ns/1ps
`default_nettype none
module fdss_pct_unit
    import fdss_pkg::*;
(
    // Clock and reset.
    input  wire logic   sys_clk,
    input  wire logic   rst,
    // Request and result.
    fdss_pct_if.unit    pct
);

    logic [15:0] result_reg;
    logic [15:0] result_next;
    logic [15:0] quot;
    logic [15:0] rem;
    logic [31:0] whole_part;
    logic [31:0] frac_part;

    // Quotient times percent plus remainder times percent over one hundred.
    always_comb begin
        quot        = pct.magnitude / PCT_DIV;
        rem         = pct.magnitude % PCT_DIV;
        whole_part  = {16'h0000, quot} * {24'h000000, pct.percent};
        frac_part   = ({16'h0000, rem} * {24'h000000, pct.percent}) / {16'h0000, PCT_DIV};
        result_next = whole_part[15:0] + frac_part[15:0];
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            result_reg <= 16'h0000;
        end else begin
            result_reg <= result_next;
        end
    end

    assign pct.result = result_reg;

endmodule : fdss_pct_unit
`default_nettype wire

// ===== test/fdss_port_model.sv
// Purpose: Port pair and DAC latch that the sequencer drives.
// Assumes: Port readback returns the last word written to the pair.
// Notes:   Counts faults in write order and in latch content.
`timescale 1ns/1ps
`default_nettype none
module fdss_port_model (
    // Clock and reset.
    input  wire logic        sys_clk,
    input  wire logic        rst,
    // Bench preset of the port pair.
    input  wire logic [15:0] preset,
    input  wire logic        preset_we,
    // Sequencer writes.
    input  wire logic [15:0] out_port,
    input  wire logic        out_port_we,
    input  wire logic [11:0] dac_latch,
    input  wire logic        dac_we,
    // Readback and fault count.
    output logic      [15:0] port_in,
    output logic      [7:0]  fault_count
);
    logic dac_loaded_reg;

    ////////////////////////////////////////////////////////////////////////////
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            port_in        <= 16'ha5a5;
            fault_count    <= 8'h00;
            dac_loaded_reg <= 1'b0;
        end else begin
            if (preset_we) begin
                port_in        <= preset;
                dac_loaded_reg <= 1'b0;
            end else if (out_port_we) begin
                port_in <= out_port;
            end
            if (dac_we) begin
                dac_loaded_reg <= 1'b1;
            end
            // The amplifier enable must not rise before the latch holds the drive.
            if (out_port_we && out_port[12] && !port_in[12] && !dac_loaded_reg) begin
                fault_count <= fault_count + 8'h01;
            end
            // The latch takes the low twelve bits standing in the port pair.
            if (dac_we && dac_latch !== port_in[11:0]) begin
                fault_count <= fault_count + 8'h01;
            end
        end
    end
endmodule : fdss_port_model
`default_nettype wire

// ===== test/fdss_sequencer_bench.sv
// Purpose: Self-checking bench for the start sequencer.
// Assumes: Inputs change at the falling edge; results follow the walk.
// Notes:   A reference model recomputes every breakpoint.
`timescale 1ns/1ps
`default_nettype none
module fdss_sequencer_bench;
    logic        sys_clk, rst, start, drive_down_flag, profile_tick, preset_we;
    logic [15:0] position_error, present_position, system_flags, port_in, preset;
    logic        busy, done, tick_accept, filter_overflow, brake_cmd, out_port_we, dac_we, timer_we;
    logic [15:0] ramp_breakpoint_one, ramp_breakpoint_two, previous_position, screw_sensor_last;
    logic [15:0] screw_transition_count, filter_accum, measured_velocity, out_port, timer_ctrl;
    logic [7:0]  ramp_pace_counter, backup_tick_counter, fault_count;
    logic [2:0]  profile_region_index;
    logic [11:0] dac_latch;
    logic [31:0] rnd;
    logic [63:0] tbl [8];
    int          fails, cmp_count, cycles;

    fdss_sequencer uut (.sys_clk(sys_clk), .rst(rst), .start(start), .position_error(position_error),
        .present_position(present_position), .drive_down_flag(drive_down_flag), .system_flags(system_flags),
        .port_in(port_in), .profile_tick(profile_tick), .busy(busy), .done(done), .tick_accept(tick_accept),
        .ramp_breakpoint_one(ramp_breakpoint_one), .ramp_breakpoint_two(ramp_breakpoint_two),
        .previous_position(previous_position), .screw_sensor_last(screw_sensor_last),
        .screw_transition_count(screw_transition_count), .filter_overflow(filter_overflow),
        .filter_accum(filter_accum), .measured_velocity(measured_velocity), .ramp_pace_counter(ramp_pace_counter),
        .profile_region_index(profile_region_index), .backup_tick_counter(backup_tick_counter),
        .brake_cmd(brake_cmd), .out_port(out_port), .out_port_we(out_port_we), .dac_latch(dac_latch),
        .dac_we(dac_we), .timer_ctrl(timer_ctrl), .timer_we(timer_we));

    fdss_port_model amp (.sys_clk(sys_clk), .rst(rst), .preset(preset), .preset_we(preset_we),
        .out_port(out_port), .out_port_we(out_port_we), .dac_latch(dac_latch), .dac_we(dac_we),
        .port_in(port_in), .fault_count(fault_count));

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        sys_clk = 1'b0;
        forever #4 sys_clk = ~sys_clk;
    end

    always @(posedge sys_clk) begin
        cycles <= cycles + 1;
        if (cycles == 1000) begin
            fails = fails + 1;
            give_verdict();
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] lfsr_next(input logic [31:0] x);
        for (int k = 0; k < 16; k++) begin
            x = {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
        end
        return x;
    endfunction : lfsr_next

    task automatic chk(input logic [15:0] got, input logic [15:0] want);
        cmp_count = cmp_count + 1;
        if (got !== want) begin
            fails = fails + 1;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, want);
        end
    endtask : chk

    task automatic ref_calc(input int e, input int pp, input bit dn, input bit man, output int b1, output int b2);
        int ae, m1, m2;
        ae = (e >= 32768) ? 65536 - e : e;
        m1 = (ae / 100) * 7 + ((ae % 100) * 7) / 100;
        if (man && m1 <= 60) m1 = 60;
        m2 = (ae / 100) * 90 + ((ae % 100) * 90) / 100;
        if (man && ae - m2 < 65) m2 = (ae - 65) & 32'h0000ffff;
        b1 = (dn ? pp - m1 : pp + m1) & 32'h0000ffff;
        b2 = (dn ? pp - m2 : pp + m2) & 32'h0000ffff;
    endtask : ref_calc

    task automatic run_one(input logic [15:0] e, input logic [15:0] pp, input logic dn, input logic [15:0] fl,
                           input logic [15:0] pre);
        int          b1, b2;
        logic [15:0] drv, want_port;
        ref_calc(e, pp, dn, fl[1], b1, b2);
        drv = dn ? 16'h0ffc : 16'h0004;
        want_port = (pre & 16'hf000) | drv;
        preset = pre;
        preset_we = 1'b1;
        position_error = e;
        present_position = pp;
        drive_down_flag = dn;
        system_flags = fl;
        start = 1'b1;
        for (int i = 1; i <= 11; i++) begin
            @(negedge sys_clk);
            chk({8'h00, brake_cmd, out_port_we, dac_we, timer_we, done, busy, tick_accept, 1'b0},
                {8'h00, i == 5, i == 7 || i == 9, i == 8, i == 10, i == 11, i <= 10, 2'b00});
            if (i == 7) chk(out_port, want_port);
            if (i == 8) chk({4'h0, dac_latch}, drv);
            if (i == 9) chk(out_port, want_port | 16'h1000);
            if (i == 10) chk(timer_ctrl, 16'he001);
            if (i < 11) start = (i == 4);
            if (i == 1) begin
                preset_we = 1'b0;
                position_error = ~e;
                present_position = ~pp;
                drive_down_flag = ~dn;
                system_flags = ~fl;
            end
        end
        chk(ramp_breakpoint_one, b1[15:0]);
        chk(ramp_breakpoint_two, b2[15:0]);
        chk(previous_position, pp);
        chk(screw_sensor_last, pp);
        chk(screw_transition_count | filter_accum | {15'h0000, filter_overflow}, 16'h0000);
        chk(measured_velocity, 16'h0000);
        chk({8'h00, ramp_pace_counter}, 16'h001e);
        chk({13'h0000, profile_region_index}, 16'h0000);
        chk({8'h00, backup_tick_counter}, 16'h0019);
        $display("test done err=%h pos=%h down=%b flags=%h", e, pp, dn, fl);
    endtask : run_one

    task automatic give_verdict();
        $display("comparisons=%0d mismatches=%0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : give_verdict

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        fails = 0;
        cmp_count = 0;
        cycles = 0;
        rnd = 32'h00015d85;
        rst = 1'b1;
        start = 1'b0;
        position_error = 16'h0000;
        present_position = 16'h0000;
        drive_down_flag = 1'b0;
        system_flags = 16'h0000;
        profile_tick = 1'b0;
        preset = 16'h0000;
        preset_we = 1'b0;
        tbl = '{{16'h0368, 16'h1000, 16'h0002, 16'h0000}, {16'h0359, 16'h1000, 16'h0002, 16'h0001},
                {16'h028a, 16'h2000, 16'h0002, 16'h0000}, {16'h0280, 16'h2000, 16'h0002, 16'h0001},
                {16'h001e, 16'h0100, 16'h0002, 16'h0000}, {16'h8000, 16'h0010, 16'hfffd, 16'h0001},
                {16'hfc98, 16'h4000, 16'h0000, 16'h0000}, {16'h7fff, 16'hfff0, 16'h0002, 16'h0000}};
        repeat (10) @(negedge sys_clk);
        rst = 1'b0;
        @(negedge sys_clk);
        chk(out_port | ramp_breakpoint_one | {13'h0000, profile_region_index}, 16'h0000);
        profile_tick = 1'b1;
        #1;
        chk({15'h0000, tick_accept}, 16'h0001);
        @(negedge sys_clk);
        for (int n = 0; n < 8; n++) begin
            rnd = lfsr_next(rnd);
            run_one(tbl[n][63:48], tbl[n][47:32], tbl[n][0], tbl[n][31:16], rnd[15:0]);
        end
        for (int n = 0; n < 16; n++) begin
            rnd = lfsr_next(rnd);
            run_one(rnd[15:0], rnd[31:16], rnd[5], 16'(lfsr_next(rnd)), rnd[31:16] ^ rnd[15:0]);
        end
        @(negedge sys_clk);
        chk({8'h00, fault_count}, 16'h0000);
        give_verdict();
    end
endmodule : fdss_sequencer_bench
`default_nettype wire
